/* File: wcr_defines.vh */
// constants of the waveform capture trigger and retrieval block
// assumes word addressing on the register-access port, one word per address
`ifndef WCR_DEFINES_VH
`define WCR_DEFINES_VH

// ****************************************************************
// register word addresses
// ****************************************************************
`define WCR_ADDR_GROUP_PTR 16'h8E00
`define WCR_ADDR_SELECTOR 16'h8E01
`define WCR_ADDR_STATUS 16'h8E02
`define WCR_ADDR_NEWEST 16'h8E03
`define WCR_ADDR_WIN_FIRST 16'h8E04
`define WCR_ADDR_WIN_LAST 16'h8E43
// words in a read that covers 8E00 through 8E43 in one go
`define WCR_FULL_SPAN 16'h0044

// ****************************************************************
// field ranges and reset values
// ****************************************************************
`define WCR_PTR_MIN 16'h0001
`define WCR_PTR_MAX 16'h0064
`define WCR_PTR_STEP 16'h0004
`define WCR_PTR_RESET 16'h0001
`define WCR_SEL_REASONS 16'h0000
`define WCR_SEL_FIRST_BLOCK 16'h0001
`define WCR_SEL_MAX 16'h0079
`define WCR_SEL_RESET 16'h0000
`define WCR_STORE_GROUPS 16'h0064
`define WCR_NEWEST_RESET 16'h0000

// ****************************************************************
// window status codes
// ****************************************************************
`define WCR_STAT_VALID 16'h000B
`define WCR_STAT_INVALID 16'h00FF
`define WCR_STAT_CLEARING 16'h00AA

// ****************************************************************
// over-current comparison and sample scaling
// ****************************************************************
`define WCR_PERCENT 32'h00000064
// raw-to-real divisors, times 100000: volts, amps, amps with 333mV CT
`define WCR_VOLT_DIV_E5 32'd3759105
`define WCR_CURR_DIV_E5 32'd168315300
`define WCR_CURR333_DIV_E5 32'd1586987000

`endif

/* File: wcr_capture_retrieve.v */
// waveform capture trigger logic and the register retrieval window
// assumes all inputs come from logic on clk; sample words come from an
// external capture store and are taken while mem_rd stands
`timescale 1ns/100ps
`include "wcr_defines.vh"

module wcr_capture_retrieve (
   // clock, reset, clock enable
   input wire clk,
   input wire reset,
   input wire ce,
   // trigger configuration
   input wire sag_capture_en,
   input wire swell_capture_en,
   input wire oc_capture_en,
   input wire [15:0] oc_rated,
   input wire [15:0] oc_threshold,
   // detections and phase currents
   input wire [2:0] sag_detect,
   input wire [2:0] swell_detect,
   input wire [15:0] phase_current_1,
   input wire [15:0] phase_current_2,
   input wire [15:0] phase_current_3,
   // capture store handshake
   input wire store_write_done,
   input wire store_clearing,
   output reg capture_start,
   output reg event_log_start,
   output reg [8:0] capture_reason,
   output reg [15:0] capture_group,
   output reg capture_busy,
   // register-access port, writes
   input wire wr_en,
   input wire [15:0] wr_addr,
   input wire [15:0] wr_data,
   // register-access port, block reads
   input wire rd_start,
   input wire [15:0] rd_addr,
   input wire [15:0] rd_count,
   output reg rd_busy,
   output reg rd_valid,
   output reg rd_last,
   output reg [15:0] rd_data,
   // sample fetch from the capture store
   output reg mem_rd,
   output reg [15:0] mem_group,
   output reg [15:0] mem_block,
   output reg [5:0] mem_word,
   input wire [15:0] mem_rdata
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   localparam ST_IDLE = 3'b001;
   localparam ST_READ = 3'b010;
   localparam ST_DONE = 3'b100;

   reg [2:0] state;
   reg [15:0] group_ptr;
   reg [15:0] selector;
   reg [15:0] window_status;
   reg [15:0] newest_group;
   reg oc_armed;
   reg [15:0] cur_addr;
   reg [15:0] remaining;
   reg full_read;
   reg valid_at_start;
   reg s1_valid;
   reg s1_last;
   reg s1_is_mem;
   reg [15:0] s1_data;

   reg [2:0] next_state;
   reg [15:0] next_status;
   reg [2:0] oc_over;
   reg [15:0] reg_value;
   wire [31:0] oc_limit;
   wire [31:0] cur1_scaled;
   wire [31:0] cur2_scaled;
   wire [31:0] cur3_scaled;
   wire store_full;
   wire sag_hit;
   wire swell_hit;
   wire oc_hit;
   wire trigger_any;
   wire trigger_ok;
   wire in_window;
   wire [15:0] ptr_stepped;
   wire [5:0] word_index;

   // ****************************************************************
   // trigger qualification
   // ****************************************************************

   // current times 100 against rated times percent
   assign oc_limit = {16'h0000, oc_rated} * {16'h0000, oc_threshold};
   assign cur1_scaled = {16'h0000, phase_current_1} * `WCR_PERCENT;
   assign cur2_scaled = {16'h0000, phase_current_2} * `WCR_PERCENT;
   assign cur3_scaled = {16'h0000, phase_current_3} * `WCR_PERCENT;

   // per-phase over-current level
   always @* begin
      oc_over[0] = cur1_scaled > oc_limit;
      oc_over[1] = cur2_scaled > oc_limit;
      oc_over[2] = cur3_scaled > oc_limit;
   end

   // sag detection qualified by its enable
   assign sag_hit = sag_capture_en & (|sag_detect);
   // swell detection qualified by its enable
   assign swell_hit = swell_capture_en & (|swell_detect);
   // only an armed over-current detector may fire
   assign oc_hit = oc_capture_en & oc_armed & (|oc_over);
   assign trigger_any = sag_hit | swell_hit | oc_hit;

   assign store_full = newest_group >= `WCR_STORE_GROUPS;
   // busy or clearing store refuses triggers
   assign trigger_ok = trigger_any & ~capture_busy & ~store_full & ~store_clearing;

   // ****************************************************************
   // trigger and capture store state
   // ****************************************************************

   // starts captures, tracks the write and the group count
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         capture_start <= 1'b0;
         event_log_start <= 1'b0;
         capture_reason <= 9'h000;
         capture_group <= 16'h0000;
         capture_busy <= 1'b0;
         newest_group <= `WCR_NEWEST_RESET;
         oc_armed <= 1'b1;
      end else if (ce) begin
         // event log pulse on any qualified sag or swell, whether or not a capture starts
         event_log_start <= sag_hit | swell_hit;
         capture_start <= trigger_ok;
         // disarm on any phase, rearm when all normal
         if (|oc_over) begin
            oc_armed <= 1'b0;
         end else begin
            oc_armed <= 1'b1;
         end
         if (trigger_ok) begin
            capture_reason <= {oc_hit ? oc_over : 3'b000,
                               swell_hit ? swell_detect : 3'b000,
                               sag_hit ? sag_detect : 3'b000};
            capture_group <= newest_group + 16'h0001;
            capture_busy <= 1'b1;
         end
         // emptying restarts recording at group one
         if (store_clearing) begin
            newest_group <= `WCR_NEWEST_RESET;
            capture_busy <= 1'b0;
         end else if (capture_busy && store_write_done) begin
            // triggers accepted again after the write
            capture_busy <= 1'b0;
            newest_group <= capture_group;
         end
      end
   end

   // ****************************************************************
   // window status
   // ****************************************************************

   // status code from clearing and pointer validity
   always @* begin
      if (store_clearing) begin
         next_status = `WCR_STAT_CLEARING;
      end else if (newest_group != 16'h0000 && group_ptr <= newest_group && selector <= `WCR_SEL_MAX) begin
         // pointer valid only up to newest group
         next_status = `WCR_STAT_VALID;
      end else begin
         next_status = `WCR_STAT_INVALID;
      end
   end

   // status register follows the store every cycle
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         window_status <= `WCR_STAT_INVALID;
      end else if (ce) begin
         window_status <= next_status;
      end
   end

   // ****************************************************************
   // read sequencing
   // ****************************************************************

   assign in_window = cur_addr >= `WCR_ADDR_WIN_FIRST && cur_addr <= `WCR_ADDR_WIN_LAST;
   assign word_index = cur_addr[5:0] - 6'h04;
   // step only while it stays within the newest group
   assign ptr_stepped = group_ptr + `WCR_PTR_STEP;

   // value of a plain register at the current address
   always @* begin
      case (cur_addr)
         `WCR_ADDR_GROUP_PTR: reg_value = group_ptr;
         `WCR_ADDR_SELECTOR: reg_value = selector;
         `WCR_ADDR_STATUS: reg_value = window_status;
         `WCR_ADDR_NEWEST: reg_value = newest_group;
         default: reg_value = 16'h0000;
      endcase
   end

   // next state of the read sequencer
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (rd_start && rd_count != 16'h0000) begin
               next_state = ST_READ;
            end
         end
         ST_READ: begin
            if (remaining == 16'h0001) begin
               next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // sequencer, first pipeline stage and sample fetch
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
         rd_busy <= 1'b0;
         cur_addr <= 16'h0000;
         remaining <= 16'h0000;
         full_read <= 1'b0;
         valid_at_start <= 1'b0;
         s1_valid <= 1'b0;
         s1_last <= 1'b0;
         s1_is_mem <= 1'b0;
         s1_data <= 16'h0000;
         mem_rd <= 1'b0;
         mem_group <= 16'h0000;
         mem_block <= 16'h0000;
         mem_word <= 6'h00;
      end else if (ce) begin
         state <= next_state;
         rd_busy <= next_state != ST_IDLE;
         s1_valid <= 1'b0;
         s1_last <= 1'b0;
         mem_rd <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (rd_start && rd_count != 16'h0000) begin
                  cur_addr <= rd_addr;
                  remaining <= rd_count;
                  // only one read spanning 8E00-8E43 counts
                  full_read <= rd_addr == `WCR_ADDR_GROUP_PTR && rd_count >= `WCR_FULL_SPAN;
                  // validity sampled as the read begins
                  valid_at_start <= window_status == `WCR_STAT_VALID;
               end
            end
            ST_READ: begin
               s1_valid <= 1'b1;
               s1_last <= remaining == 16'h0001;
               s1_is_mem <= in_window;
               s1_data <= reg_value;
               cur_addr <= cur_addr + 16'h0001;
               remaining <= remaining - 16'h0001;
               if (in_window) begin
                  // selector zero fetches reasons of ptr..ptr+3
                  // selector picks reasons, timestamp or cycle block
                  mem_rd <= 1'b1;
                  mem_group <= group_ptr;
                  mem_block <= selector;
                  mem_word <= word_index;
               end
            end
            ST_DONE: begin
               full_read <= 1'b0;
            end
            default: begin
               full_read <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************************************
   // read data output
   // ****************************************************************

   // second stage joins register values and fetched samples
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_valid <= 1'b0;
         rd_last <= 1'b0;
         rd_data <= 16'h0000;
      end else if (ce) begin
         rd_valid <= s1_valid;
         rd_last <= s1_last;
         if (s1_valid) begin
            // samples pass as raw signed 16-bit words
            // scaling is left to the host divisors
            rd_data <= s1_is_mem ? mem_rdata : s1_data;
         end
      end
   end

   // ****************************************************************
   // pointer and selector registers
   // ****************************************************************

   // host writes while idle, auto advance after a full read
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         group_ptr <= `WCR_PTR_RESET;
         selector <= `WCR_SEL_RESET;
      end else if (ce) begin
         if (state == ST_IDLE && wr_en) begin
            // pointer accepts 1 to 100 only
            if (wr_addr == `WCR_ADDR_GROUP_PTR && wr_data >= `WCR_PTR_MIN && wr_data <= `WCR_PTR_MAX) begin
               group_ptr <= wr_data;
            end
            // selector accepts 0 to 121 only
            if (wr_addr == `WCR_ADDR_SELECTOR && wr_data <= `WCR_SEL_MAX) begin
               selector <= wr_data;
            end
         end else if (state == ST_DONE && full_read && valid_at_start) begin
            // advance only after a read with valid status
            if (selector == `WCR_SEL_REASONS) begin
               // stop when the step passes newest group
               if (ptr_stepped <= newest_group) begin
                  group_ptr <= ptr_stepped;
               end
            end else if (selector < `WCR_SEL_MAX) begin
               selector <= selector + 16'h0001;
            end
         end
      end
   end

endmodule

/* File: wcr_monitor.sv */
// port assertions for the capture and retrieval block
// assumes one clock, reset active high and asynchronous
`timescale 1ns/100ps

module wcr_monitor (
   // clock and reset
   input wire clk,
   input wire reset,
   input wire ce,
   // triggers and capture
   input wire sag_capture_en,
   input wire swell_capture_en,
   input wire [2:0] sag_detect,
   input wire [2:0] swell_detect,
   input wire store_clearing,
   input wire capture_start,
   input wire event_log_start,
   input wire [8:0] capture_reason,
   input wire capture_busy,
   // read port
   input wire rd_start,
   input wire [15:0] rd_count,
   input wire rd_busy,
   input wire rd_valid,
   input wire rd_last
);
   // qualified detections and read acceptance
   wire [2:0] sag_m = sag_capture_en ? sag_detect : 3'h0;
   wire [2:0] swl_m = swell_capture_en ? swell_detect : 3'h0;
   wire take = ce && rd_start && !rd_busy && rd_count != 16'h0000;
   reg [15:0] want;
   reg [15:0] seen;
   // tally of words handed back per read
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         want <= 16'h0000;
         seen <= 16'h0000;
      end else if (take) begin
         want <= rd_count;
         seen <= 16'h0000;
      end else if (rd_valid) begin
         seen <= seen + 16'h0001;
      end
   end
   default clocking mon_cb @(posedge clk); endclocking
   default disable iff (reset);
   // ****************************************************************
   // assertions
   // ****************************************************************
   sag_logged_a: assert property (ce && |sag_m |=> event_log_start) else $error("sag not logged");
   sag_reason_a: assert property (capture_start |-> capture_reason[2:0] == $past(sag_m)) else $error("sag bits");
   swell_reason_a: assert property (capture_start |-> capture_reason[5:3] == $past(swl_m)) else $error("swell bits");
   busy_holds_off_a: assert property (capture_busy |=> !capture_start) else $error("start while busy");
   start_sets_busy_a: assert property (capture_start |-> capture_busy && capture_reason != 9'h000) else $error("no busy");
   clear_holds_off_a: assert property (store_clearing |=> !capture_start) else $error("start while clearing");
   read_latency_a: assert property (take |=> rd_busy ##1 !rd_valid ##1 rd_valid) else $error("read answer late");
   read_length_a: assert property (rd_last |-> rd_valid && seen + 16'h0001 == want) else $error("word count");
   cov_capture: cover property (capture_start);
   cov_window: cover property (rd_last && want == 16'h0044);
   cov_clear_read: cover property (store_clearing && take);
endmodule

bind wcr_capture_retrieve wcr_monitor mon (.clk, .reset, .ce, .sag_capture_en, .swell_capture_en, .sag_detect,
   .swell_detect, .store_clearing, .capture_start, .event_log_start, .capture_reason, .capture_busy, .rd_start,
   .rd_count, .rd_busy, .rd_valid, .rd_last);

/* File: wcr_store_model.sv */
// capture store and group writer behind the block
// assumes the block takes fetched data in the cycle that mem_rd stands
`timescale 1ns/100ps

module wcr_store_model (
   // clock and reset
   input wire clk,
   input wire reset,
   // requests from the block
   input wire mem_rd,
   input wire [15:0] mem_group,
   input wire [15:0] mem_block,
   input wire [5:0] mem_word,
   input wire capture_start,
   // answers
   output reg [15:0] mem_rdata,
   output reg store_write_done
);
   reg [2:0] wait_cnt;
   // raw words from the fetch fields while mem_rd stands, the inverse otherwise
   always @* begin
      mem_rdata = mem_rd ? {mem_group[3:0], mem_block[5:0], mem_word} : ~{mem_group[3:0], mem_block[5:0], mem_word};
   end
   // group write ends five cycles after start
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         store_write_done <= 1'b0;
         wait_cnt <= 3'h0;
      end else begin
         store_write_done <= (wait_cnt == 3'h1);
         wait_cnt <= capture_start ? 3'h4 : wait_cnt - {2'h0, wait_cnt != 3'h0};
      end
   end
endmodule

/* File: test_waveform_capture_retrieval.sv */
// self-checking bench for the capture and retrieval block
// assumes the store model answers fetches and ends group writes
`timescale 1ns/100ps

module test_waveform_capture_retrieval;
   reg clk = 1'b0, reset = 1'b1, ce = 1'b1, wr_en = 1'b0, rd_start = 1'b0, store_clearing = 1'b0;
   reg sag_capture_en = 1'b0, swell_capture_en = 1'b0, oc_capture_en = 1'b0;
   reg [2:0] sag_detect = 3'h0, swell_detect = 3'h0;
   reg [15:0] oc_rated = 16'h000A, oc_threshold = 16'h0064, phase_current_1 = 16'h0000;
   reg [15:0] phase_current_2 = 16'h0000, phase_current_3 = 16'h0000, wr_addr = 16'h0000;
   reg [15:0] wr_data = 16'h0000, rd_addr = 16'h0000, rd_count = 16'h0000;
   wire capture_start, event_log_start, capture_busy, store_write_done, rd_busy, rd_valid, rd_last, mem_rd;
   wire [8:0] capture_reason;
   wire [15:0] rd_data, mem_group, mem_block, mem_rdata, capture_group;
   wire [5:0] mem_word;
   reg [15:0] rbuf [0:67];
   integer bad_count = 0, total_checks = 0, cycles = 0;

   wcr_capture_retrieve dut (.clk, .reset, .ce, .sag_capture_en, .swell_capture_en, .oc_capture_en, .oc_rated,
      .oc_threshold, .sag_detect, .swell_detect, .phase_current_1, .phase_current_2, .phase_current_3,
      .store_write_done, .store_clearing, .capture_start, .event_log_start, .capture_reason, .capture_group,
      .capture_busy, .wr_en, .wr_addr, .wr_data, .rd_start, .rd_addr, .rd_count, .rd_busy, .rd_valid, .rd_last,
      .rd_data, .mem_rd, .mem_group, .mem_block, .mem_word, .mem_rdata);
   wcr_store_model store (.clk, .reset, .mem_rd, .mem_group, .mem_block, .mem_word, .capture_start, .mem_rdata,
      .store_write_done);

   // 40 MHz clock
   always #12.5 clk = ~clk;
   // hang guard
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 6000) begin
         bad_count = bad_count + 1;
         conclude;
      end
   end

   task tick;
      @(posedge clk) #1;
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input [15:0] a, input [15:0] d);
      tick;
      wr_en = 1'b1;
      wr_addr = a;
      wr_data = d;
      tick;
      wr_en = 1'b0;
   endtask
   // block read, words collected into rbuf
   task rd(input [15:0] a, input [15:0] n);
      reg [15:0] k;
      integer i;
      tick;
      rd_start = 1'b1;
      rd_addr = a;
      rd_count = n;
      tick;
      rd_start = 1'b0;
      k = 16'h0000;
      for (i = 0; i < 100 && k < n; i = i + 1) begin
         tick;
         if (rd_valid === 1'b1) begin
            rbuf[k] = rd_data;
            k = k + 16'h0001;
         end
      end
      chk(k, n);
      for (i = 0; i < 4 && rd_busy !== 1'b0; i = i + 1)
         tick;
   endtask
   // one-cycle detection, returns in the cycle of the answer
   task pulse(input [2:0] sg, input [2:0] sw);
      tick;
      sag_detect = sg;
      swell_detect = sw;
      tick;
      sag_detect = 3'h0;
      swell_detect = 3'h0;
   endtask
   task idle;
      integer i;
      for (i = 0; i < 12 && capture_busy !== 1'b0; i = i + 1)
         tick;
      tick;
   endtask

   task t_reset;
      rd(16'h8E00, 16'h0004);
      chk(rbuf[0], 16'h0001);
      chk(rbuf[1], 16'h0000);
      chk(rbuf[2], 16'h00FF);
      chk(rbuf[3], 16'h0000);
   endtask
   // five groups from sag, swell and over-current
   task t_trig;
      pulse(3'h1, 3'h0);
      chk({14'h0000, capture_start, event_log_start}, 16'h0000);
      sag_capture_en = 1'b1;
      swell_capture_en = 1'b1;
      pulse(3'h1, 3'h0);
      chk({5'h00, event_log_start, capture_start, capture_reason}, 16'h0601);
      chk(capture_group, 16'h0001);
      idle;
      pulse(3'h0, 3'h2);
      chk({5'h00, event_log_start, capture_start, capture_reason}, 16'h0610);
      idle;
      phase_current_1 = 16'h0014;
      tick;
      chk({15'h0000, capture_start}, 16'h0000);
      phase_current_1 = 16'h0000;
      tick;
      oc_capture_en = 1'b1;
      phase_current_1 = 16'h0014;
      tick;
      chk({6'h00, capture_start, capture_reason}, 16'h0240);
      idle;
      phase_current_2 = 16'h0014;
      tick;
      chk({15'h0000, capture_start}, 16'h0000);
      phase_current_1 = 16'h000A;
      phase_current_2 = 16'h000A;
      tick;
      chk({15'h0000, capture_start}, 16'h0000);
      phase_current_3 = 16'h000B;
      tick;
      chk({6'h00, capture_start, capture_reason}, 16'h0300);
      idle;
      pulse(3'h4, 3'h0);
      chk({6'h00, capture_start, capture_reason}, 16'h0204);
      chk(capture_group, 16'h0005);
      idle;
   endtask
   task t_reason;
      wr(16'h8E01, 16'h0000);
      wr(16'h8E00, 16'h0001);
      rd(16'h8E00, 16'h0044);
      chk(rbuf[2], 16'h000B);
      chk(rbuf[3], 16'h0005);
      chk(rbuf[4], 16'h1000);
      chk(rbuf[67], 16'h103F);
      rd(16'h8E00, 16'h0043);
      chk(rbuf[0], 16'h0005);
      rd(16'h8E00, 16'h0044);
      chk(rbuf[0], 16'h0005);
      rd(16'h8E00, 16'h0001);
      chk(rbuf[0], 16'h0005);
   endtask
   task t_select;
      wr(16'h8E00, 16'h0065);
      wr(16'h8E01, 16'h007A);
      wr(16'h8E01, 16'h0078);
      rd(16'h8E00, 16'h0044);
      chk(rbuf[0], 16'h0005);
      chk(rbuf[4], 16'h5E00);
      rd(16'h8E00, 16'h0044);
      chk(rbuf[1], 16'h0079);
      rd(16'h8E00, 16'h0002);
      chk(rbuf[1], 16'h0079);
   endtask
   task t_clear;
      wr(16'h8E01, 16'h0002);
      rd(16'h8E00, 16'h0043);
      store_clearing = 1'b1;
      rd(16'h8E00, 16'h0044);
      chk(rbuf[1], 16'h0002);
      chk(rbuf[2], 16'h00AA);
      pulse(3'h1, 3'h0);
      chk({15'h0000, capture_start}, 16'h0000);
      rd(16'h8E01, 16'h0001);
      chk(rbuf[0], 16'h0002);
   endtask

   // verdict and end of run
   task conclude;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // reset for five cycles, then the scenarios
   initial begin
      repeat (5) @(posedge clk);
      #1 reset = 1'b0;
      t_reset;
      t_trig;
      t_reason;
      t_select;
      t_clear;
      conclude;
   end
endmodule
